// >>> dgm_consts.vh
`ifndef DGM_CONSTS_VH
`define DGM_CONSTS_VH
// ****************************************************************
// Register byte offsets
// ****************************************************************
`define DGM_OFS_CTRL 6'h00
`define DGM_OFS_PLEN 6'h04
`define DGM_OFS_TFORCE 6'h08
`define DGM_OFS_STAT 6'h0C
`define DGM_OFS_INSEL0 6'h10
`define DGM_OFS_INSEL1 6'h14
`define DGM_OFS_OUTSEL0 6'h18
`define DGM_OFS_OUTSEL1 6'h1C
`define DGM_OFS_MARK 6'h20
// ****************************************************************
// Field positions, reset values and pulse length limits
// ****************************************************************
`define DGM_CTRL_EN 0
`define DGM_CTRL_TEST 1
`define DGM_CTRL_RST 2'h0
`define DGM_PLEN_RST 10'h0FA
`define DGM_PLEN_MIN 10'h064
`define DGM_PLEN_MAX 10'h3E8
// ****************************************************************
// Timing
// ****************************************************************
`define DGM_CLK_HZ 50000000
`define DGM_CLK_PER_MS (`DGM_CLK_HZ / 1000)
// ****************************************************************
// Function codes, shared by inputs and outputs
// ****************************************************************
`define DGM_F_NONE 6'h00
`define DGM_F_BUILD 6'h01
`define DGM_F_EXIT 6'h02
`define DGM_F_COUGH 6'h03
`define DGM_F_DUMP 6'h04
`define DGM_F_BYPASS 6'h05
`define DGM_F_PAUSE 6'h06
`define DGM_F_PMARK 6'h08
`define DGM_F_LMARK 6'h10
`define DGM_F_PASS 6'h18
`define DGM_F_MAX_P 6'h21
`define DGM_F_ZERO_P 6'h22
`define DGM_F_L_RAMP 6'h23
`define DGM_F_L_UNW 6'h24
`define DGM_F_L_DISC 6'h25
`define DGM_F_L_SIL 6'h26
`define DGM_F_BUILDING 6'h27
`define DGM_F_EXITING 6'h28
`define DGM_F_AT_MAX 6'h29
`define DGM_F_SZ_MET 6'h2A
`define DGM_F_SZ_NOT 6'h2B
`define DGM_F_AT_ZERO 6'h2C
`define DGM_F_SGL_DISC 6'h2D
`define DGM_F_MUTED 6'h2E
`endif

// >>> dgm_pulse.v
`timescale 1ns/1ps
// ****************************************************************
// One-shot pulse of len_ms milliseconds; triggers while high are ignored.
// ****************************************************************
module dgm_pulse #(
   parameter CPM = 50000,
   parameter CW = 16
) (
   input wire hclk,
   input wire hresetn,
   input wire trig,
   input wire [9:0] len_ms,
   output reg q
);
   reg [9:0] ms_r;
   reg [CW-1:0] cyc_r;
   localparam [CW-1:0] CYC_TOP = CPM - 1;

   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         q <= 1'b0;
         ms_r <= 10'h000;
         cyc_r <= {CW{1'b0}};
      end else if (!q) begin
         if (trig) begin
            q <= 1'b1;
            ms_r <= len_ms;
            cyc_r <= CYC_TOP;
         end
      end else if (cyc_r == {CW{1'b0}}) begin
         cyc_r <= CYC_TOP;
         if (ms_r == 10'h001) begin
            q <= 1'b0;
         end
         ms_r <= ms_r - 10'h001;
      end else begin
         cyc_r <= cyc_r - {{(CW-1){1'b0}}, 1'b1};
      end
   end
endmodule

// >>> dgm_mem.v
`timescale 1ns/1ps
// ****************************************************************
// Marker memory, one word per audio sample, registered read.
// ****************************************************************
module dgm_mem #(
   parameter AW = 16,
   parameter DW = 16
) (
   input wire hclk,
   input wire hresetn,
   input wire we,
   input wire [AW-1:0] waddr,
   input wire [DW-1:0] wdata,
   input wire re,
   input wire [AW-1:0] raddr,
   output reg [DW-1:0] rdata
);
   reg [DW-1:0] mem [0:(1<<AW)-1];

   always @(posedge hclk) begin
      if (we) begin
         mem[waddr] <= wdata;
      end
   end

   // Read data stand one cycle after the read strobe, while the caller's delayed strobe is high.
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         rdata <= {DW{1'b0}};
      end else if (re) begin
         rdata <= mem[raddr];
      end
   end
endmodule

// >>> dgm_gpio.v
`timescale 1ns/1ps
`include "dgm_consts.vh"
module dgm_gpio #(
   parameter CLK_PER_MS = `DGM_CLK_PER_MS,
   parameter AW = 16,
   parameter NIO = 8
) (
   input wire hclk,
   input wire hresetn,
   input wire hsel,
   input wire [31:0] haddr,
   input wire [1:0] htrans,
   input wire hwrite,
   input wire [2:0] hsize,
   input wire [31:0] hwdata,
   input wire hready,
   output reg hreadyout,
   output reg hresp,
   output reg [31:0] hrdata,
   input wire [NIO-1:0] gpio_in,
   output reg [NIO-1:0] gpio_out,
   input wire st_building,
   input wire st_exiting,
   input wire st_full,
   input wire st_empty,
   input wire st_size_met,
   input wire st_dump_ready,
   input wire st_bypass,
   input wire st_hold,
   input wire dump_evt,
   input wire lamp_ramp,
   input wire lamp_unwind,
   input wire lamp_discard,
   input wire lamp_silence,
   input wire aud_wr,
   input wire [AW-1:0] aud_wr_addr,
   input wire aud_rd,
   input wire aud_rd_skip,
   input wire [AW-1:0] aud_rd_addr,
   input wire aud_splice,
   output reg cmd_build,
   output reg cmd_exit,
   output reg cmd_cough,
   output reg cmd_dump,
   output reg cmd_bypass,
   output reg cough_held,
   output reg dump_held,
   output reg ramp_pause
);
   integer i;
   // ****************************************************************
   // Register file and AHB-Lite slave
   // ****************************************************************
   reg en_r;
   reg test_r;
   reg [9:0] plen_r;
   reg [NIO-1:0] tforce_r;
   reg [5:0] in_sel_r [0:NIO-1];
   reg [5:0] out_sel_r [0:NIO-1];
   reg ph_r;
   reg wr_r;
   reg [5:0] adr_r;
   reg [NIO-1:0] lvl_r;
   reg [7:0] lm_r;
   wire wr_en = ph_r & wr_r;

   function [31:0] sel_word;
      input [5:0] a;
      input [5:0] b;
      input [5:0] c;
      input [5:0] d;
      begin
         sel_word = {2'b00, d, 2'b00, c, 2'b00, b, 2'b00, a};
      end
   endfunction

   function [9:0] clamp_ms;
      input [31:0] v;
      begin
         if (v < {22'h0, `DGM_PLEN_MIN}) begin
            clamp_ms = `DGM_PLEN_MIN;
         end else if (v > {22'h0, `DGM_PLEN_MAX}) begin
            clamp_ms = `DGM_PLEN_MAX;
         end else begin
            clamp_ms = v[9:0];
         end
      end
   endfunction

   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ph_r <= 1'b0;
         wr_r <= 1'b0;
         adr_r <= 6'h00;
         hreadyout <= 1'b1;
         hresp <= 1'b0;
         hrdata <= 32'h00000000;
      end else if (ph_r) begin
         ph_r <= 1'b0;
         hreadyout <= 1'b1;
         if (!wr_r) begin
            case (adr_r)
               `DGM_OFS_CTRL: hrdata <= {30'h0, test_r, en_r};
               `DGM_OFS_PLEN: hrdata <= {22'h0, plen_r};
               `DGM_OFS_TFORCE: hrdata <= {24'h0, tforce_r};
               `DGM_OFS_STAT: hrdata <= {16'h0, gpio_out, lvl_r};
               `DGM_OFS_INSEL0: hrdata <= sel_word(in_sel_r[0], in_sel_r[1],
                  in_sel_r[2], in_sel_r[3]);
               `DGM_OFS_INSEL1: hrdata <= sel_word(in_sel_r[4], in_sel_r[5],
                  in_sel_r[6], in_sel_r[7]);
               `DGM_OFS_OUTSEL0: hrdata <= sel_word(out_sel_r[0], out_sel_r[1],
                  out_sel_r[2], out_sel_r[3]);
               `DGM_OFS_OUTSEL1: hrdata <= sel_word(out_sel_r[4], out_sel_r[5],
                  out_sel_r[6], out_sel_r[7]);
               `DGM_OFS_MARK: hrdata <= {24'h0, lm_r};
               default: hrdata <= 32'h00000000;
            endcase
         end
      end else if (hsel && htrans[1] && hready) begin
         ph_r <= 1'b1;
         wr_r <= hwrite;
         adr_r <= {haddr[7:2], 2'b00} == 8'h00 ? 6'h00 : {haddr[5:2], 2'b00};
         hreadyout <= 1'b0;
      end
   end

   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         en_r <= 1'b0;
         test_r <= 1'b0;
         plen_r <= `DGM_PLEN_RST;
         tforce_r <= {NIO{1'b0}};
         for (i = 0; i < NIO; i = i + 1) begin
            in_sel_r[i] <= `DGM_F_NONE;
            out_sel_r[i] <= `DGM_F_NONE;
         end
      end else if (wr_en) begin
         case (adr_r)
            `DGM_OFS_CTRL: begin
               en_r <= hwdata[`DGM_CTRL_EN];
               test_r <= hwdata[`DGM_CTRL_TEST];
               if (!hwdata[`DGM_CTRL_TEST]) begin
                  tforce_r <= {NIO{1'b0}};
               end
            end
            `DGM_OFS_PLEN: plen_r <= clamp_ms(hwdata);
            `DGM_OFS_TFORCE: begin
               if (test_r) begin
                  tforce_r <= hwdata[NIO-1:0];
               end
            end
            `DGM_OFS_INSEL0, `DGM_OFS_INSEL1: begin
               for (i = 0; i < 4; i = i + 1) begin
                  in_sel_r[i + (adr_r[2] ? 4 : 0)] <= hwdata[8*i +: 6];
               end
            end
            `DGM_OFS_OUTSEL0, `DGM_OFS_OUTSEL1: begin
               for (i = 0; i < 4; i = i + 1) begin
                  out_sel_r[i + (adr_r[2] ? 4 : 0)] <= hwdata[8*i +: 6];
               end
            end
            default: begin
            end
         endcase
      end
   end

   // ****************************************************************
   // Input synchronisers and edge detection
   // ****************************************************************
   reg [NIO-1:0] s1_r;
   reg [NIO-1:0] s2_r;
   reg [NIO-1:0] s3_r;
   reg [NIO-1:0] act_d_r;
   wire [NIO-1:0] lvl_nxt = (~(s2_r ^ s3_r) & s3_r) | ((s2_r ^ s3_r) & lvl_r);
   // Functions see nothing while disabled or while the port is under test.
   wire [NIO-1:0] act = lvl_r & {NIO{en_r & ~test_r}};
   wire [NIO-1:0] rise = act & ~act_d_r;

   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         s1_r <= {NIO{1'b0}};
         s2_r <= {NIO{1'b0}};
         s3_r <= {NIO{1'b0}};
         lvl_r <= {NIO{1'b0}};
         act_d_r <= {NIO{1'b0}};
      end else begin
         s1_r <= gpio_in;
         s2_r <= s1_r;
         s3_r <= s2_r;
         lvl_r <= lvl_nxt;
         act_d_r <= act;
      end
   end

   // ****************************************************************
   // Fan-in of inputs onto function codes
   // ****************************************************************
   reg [63:0] frise;
   reg [63:0] flvl;

   always @* begin
      frise = 64'h0000000000000000;
      flvl = 64'h0000000000000000;
      for (i = 0; i < NIO; i = i + 1) begin
         frise[in_sel_r[i]] = frise[in_sel_r[i]] | rise[i];
         flvl[in_sel_r[i]] = flvl[in_sel_r[i]] | act[i];
      end
      frise[`DGM_F_NONE] = 1'b0;
      flvl[`DGM_F_NONE] = 1'b0;
   end

   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         cmd_build <= 1'b0;
         cmd_exit <= 1'b0;
         cmd_cough <= 1'b0;
         cmd_dump <= 1'b0;
         cmd_bypass <= 1'b0;
         cough_held <= 1'b0;
         dump_held <= 1'b0;
         ramp_pause <= 1'b0;
      end else begin
         cmd_build <= frise[`DGM_F_BUILD];
         cmd_exit <= frise[`DGM_F_EXIT];
         cmd_cough <= frise[`DGM_F_COUGH];
         cmd_dump <= frise[`DGM_F_DUMP];
         cmd_bypass <= frise[`DGM_F_BYPASS];
         cough_held <= flvl[`DGM_F_COUGH];
         dump_held <= flvl[`DGM_F_DUMP];
         ramp_pause <= flvl[`DGM_F_PAUSE];
      end
   end

   // ****************************************************************
   // Markers travelling with the audio
   // ****************************************************************
   reg [7:0] pm_pend_r;
   reg [7:0] sp_pend_r;
   reg rv_r;
   reg rs_r;
   wire [15:0] mk_q;
   wire [7:0] pm_now = pm_pend_r | frise[`DGM_F_PMARK +: 8];
   wire [7:0] pm_skip = rs_r ? mk_q[7:0] : 8'h00;
   wire [7:0] pm_fire = (rv_r ? mk_q[7:0] : 8'h00) |
      (aud_splice ? (sp_pend_r | pm_skip) : 8'h00);

   dgm_mem #(
      .AW(AW),
      .DW(16)
   ) u_mem (
      .hclk(hclk),
      .hresetn(hresetn),
      .we(aud_wr),
      .waddr(aud_wr_addr),
      .wdata({flvl[`DGM_F_LMARK +: 8], pm_now}),
      .re(aud_rd | aud_rd_skip),
      .raddr(aud_rd_addr),
      .rdata(mk_q)
   );

   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         pm_pend_r <= 8'h00;
         sp_pend_r <= 8'h00;
         rv_r <= 1'b0;
         rs_r <= 1'b0;
         lm_r <= 8'h00;
      end else begin
         // An event landing with the write goes into that word; the pending bits clear.
         pm_pend_r <= aud_wr ? 8'h00 : pm_now;
         rv_r <= aud_rd;
         rs_r <= aud_rd_skip;
         sp_pend_r <= aud_splice ? 8'h00 : (sp_pend_r | pm_skip);
         if (rv_r) begin
            lm_r <= mk_q[15:8];
         end
      end
   end

   // ****************************************************************
   // Trigger pulse generators
   // ****************************************************************
   reg bld_d_r;
   reg full_d_r;
   reg empty_d_r;
   wire [11:0] trig = {pm_fire, dump_evt, st_empty & ~empty_d_r,
      st_full & ~full_d_r, st_building & ~bld_d_r};
   wire [11:0] pq;

   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         bld_d_r <= 1'b0;
         full_d_r <= 1'b0;
         empty_d_r <= 1'b0;
      end else begin
         bld_d_r <= st_building;
         full_d_r <= st_full;
         empty_d_r <= st_empty;
      end
   end

   genvar g;
   generate
      for (g = 0; g < 12; g = g + 1) begin : gp
         dgm_pulse #(
            .CPM(CLK_PER_MS),
            .CW(16)
         ) u_p (
            .hclk(hclk),
            .hresetn(hresetn),
            .trig(trig[g]),
            .len_ms(plen_r),
            .q(pq[g])
         );
      end
   endgenerate

   // ****************************************************************
   // Output selection; an asserted function drives its pin low, except in test mode where TFORCE drives the pins
   // ****************************************************************
   reg [63:0] av;
   reg [NIO-1:0] on_nxt;

   always @* begin
      av = 64'h0000000000000000;
      av[`DGM_F_BUILD] = pq[0];
      av[`DGM_F_MAX_P] = pq[1];
      av[`DGM_F_ZERO_P] = pq[2];
      av[`DGM_F_DUMP] = pq[3];
      av[`DGM_F_BYPASS] = st_bypass;
      av[`DGM_F_PMARK +: 8] = pq[11:4];
      av[`DGM_F_LMARK +: 8] = lm_r;
      av[`DGM_F_PASS +: 4] = flvl[`DGM_F_PASS +: 4];
      av[`DGM_F_L_RAMP] = lamp_ramp;
      av[`DGM_F_L_UNW] = lamp_unwind;
      av[`DGM_F_L_DISC] = lamp_discard;
      av[`DGM_F_L_SIL] = lamp_silence;
      av[`DGM_F_BUILDING] = st_building;
      av[`DGM_F_EXITING] = st_exiting;
      av[`DGM_F_AT_MAX] = st_full;
      av[`DGM_F_SZ_MET] = st_size_met;
      av[`DGM_F_SZ_NOT] = ~st_size_met;
      av[`DGM_F_AT_ZERO] = st_empty;
      av[`DGM_F_SGL_DISC] = st_dump_ready;
      av[`DGM_F_MUTED] = st_hold & st_empty;
      for (i = 0; i < NIO; i = i + 1) begin
         on_nxt[i] = av[out_sel_r[i]];
      end
   end

   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         gpio_out <= {NIO{1'b1}};
      end else if (test_r) begin
         gpio_out <= ~tforce_r;
      end else begin
         gpio_out <= ~on_nxt;
      end
   end
endmodule

// >>> dgm_gpio_properties.sv
`timescale 1ns/1ps
// ****
// Bus and pin timing checks.
// ****
module dgm_gpio_chk #(
   parameter NIO = 8
) (
   input wire hclk,
   input wire hresetn,
   input wire hsel,
   input wire [1:0] htrans,
   input wire hready,
   input wire hreadyout,
   input wire hresp,
   input wire [31:0] hrdata,
   input wire [NIO-1:0] gpio_in,
   input wire [NIO-1:0] gpio_out,
   input wire cmd_build,
   input wire cmd_dump,
   input wire cough_held,
   input wire ramp_pause
);
   reg [7:0] pin_hist_r;
   // Remembers pin activity long enough to cover the synchroniser delay.
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         pin_hist_r <= 8'h00;
      end else begin
         pin_hist_r <= {pin_hist_r[6:0], |gpio_in};
      end
   end
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);
   sequence s_addr_phase;
      hsel && htrans[1] && hready;
   endsequence
   sequence s_one_wait;
      !hreadyout ##1 hreadyout;
   endsequence
   a_one_wait: assert property (s_addr_phase |=> s_one_wait)
      else $error("bus wait state wrong");
   a_wait_short: assert property (!hreadyout |=> hreadyout)
      else $error("bus wait too long");
   a_resp_okay: assert property (hresp == 1'b0)
      else $error("bus response not okay");
   a_rdata_holds: assert property (!$stable(hrdata) |-> !$past(hreadyout))
      else $error("read data moved outside a transfer");
   a_cmd_one_cycle: assert property (cmd_build |=> !cmd_build)
      else $error("build command longer than one cycle");
   a_dump_single: assert property ($rose(cmd_dump) |=> $fell(cmd_dump))
      else $error("dump command longer than one cycle");
   a_cmd_from_pin: assert property ((cmd_build || cmd_dump) |-> pin_hist_r != 8'h00)
      else $error("command without pin activity");
   a_held_from_pin: assert property ((cough_held || ramp_pause) |-> pin_hist_r != 8'h00)
      else $error("held level without pin activity");
   a_reset_idle: assert property ($rose(hresetn) |-> gpio_out == {NIO{1'b1}} && hreadyout)
      else $error("outputs not idle after reset");
endmodule

bind dgm_gpio dgm_gpio_chk #(.NIO(NIO)) i_dgm_gpio_chk (
   .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .htrans(htrans), .hready(hready),
   .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .gpio_in(gpio_in),
   .gpio_out(gpio_out), .cmd_build(cmd_build), .cmd_dump(cmd_dump),
   .cough_held(cough_held), .ramp_pause(ramp_pause));

// >>> dgm_remote.sv
`timescale 1ns/1ps
// ****
// Remote panel: momentary closures and held contacts.
// ****
module dgm_remote #(
   parameter HOLD = 6
) (
   input wire hclk,
   input wire [7:0] tap,
   input wire tap_go,
   input wire [7:0] level,
   output wire [7:0] gpio_in
);
   reg [7:0] tap_r = 8'h00;
   integer left = 0;
   // A tap stays made for HOLD periods so the synchroniser cannot miss it.
   always @(posedge hclk) begin
      if (tap_go) begin
         tap_r <= tap;
         left <= HOLD;
      end else if (left > 1) begin
         left <= left - 1;
      end else begin
         tap_r <= 8'h00;
         left <= 0;
      end
   end
   assign gpio_in = tap_r | level;
endmodule

// >>> tb_top.sv
`timescale 1ns/1ps
// ****
// Port mapper bench.
// ****
module tb_top;
   logic hclk = 1'b0;
   logic hresetn = 1'b0;
   logic hsel = 1'b0;
   logic hwrite = 1'b0;
   logic [1:0] htrans = 2'h0;
   logic [31:0] haddr = 32'h0;
   logic [31:0] hwdata = 32'h0;
   logic [7:0] tap = 8'h00;
   logic tap_go = 1'b0;
   logic [7:0] level = 8'h00;
   logic [7:0] st = 8'h00;
   logic [3:0] lmp = 4'h0;
   logic aud_wr = 1'b0;
   logic aud_rd = 1'b0;
   logic dump_evt = 1'b0;
   logic [5:0] aud_addr = 6'h00;
   wire hreadyout, hresp, cough_held, dump_held, ramp_pause;
   wire [31:0] hrdata;
   wire [7:0] gpio_in, gpio_out;
   wire [4:0] cmdv;
   logic [5:0] osel [0:7] = '{default: 6'h00};
   int cnt [0:4] = '{default: 0};
   int base [0:4];
   int n_mismatch = 0;
   int check_count = 0;
   int i, r, n;
   logic [31:0] rd;
   logic [63:0] sv;
   always #10 hclk = ~hclk;
   dgm_gpio #(.CLK_PER_MS(10), .AW(6)) i_dgm_gpio (
      .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
      .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .gpio_in(gpio_in),
      .gpio_out(gpio_out), .st_building(st[0]), .st_exiting(st[1]), .st_full(st[2]),
      .st_empty(st[3]), .st_size_met(st[4]), .st_dump_ready(st[5]), .st_bypass(st[6]),
      .st_hold(st[7]), .dump_evt(dump_evt), .lamp_ramp(lmp[0]), .lamp_unwind(lmp[1]),
      .lamp_discard(lmp[2]), .lamp_silence(lmp[3]), .aud_wr(aud_wr),
      .aud_wr_addr(aud_addr), .aud_rd(aud_rd), .aud_rd_skip(1'b0), .aud_rd_addr(aud_addr),
      .aud_splice(1'b0), .cmd_build(cmdv[0]), .cmd_exit(cmdv[1]), .cmd_cough(cmdv[2]),
      .cmd_dump(cmdv[3]), .cmd_bypass(cmdv[4]), .cough_held(cough_held),
      .dump_held(dump_held), .ramp_pause(ramp_pause));
   dgm_remote i_dgm_remote (.hclk(hclk), .tap(tap), .tap_go(tap_go), .level(level),
      .gpio_in(gpio_in));
   always @(posedge hclk) begin
      foreach (cnt[k]) cnt[k] += cmdv[k];
   end
   task chk(input logic [31:0] g, input logic [31:0] e);
      check_count++;
      if (g !== e) begin
         n_mismatch++;
         $display("FAIL t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask
   task conclude;
      $display("checks=%0d mismatches=%0d", check_count, n_mismatch);
      if (n_mismatch == 0 && check_count > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask
   task ahb(input logic wr, input logic [31:0] a, input logic [31:0] wd);
      int k;
      k = 0;
      hsel <= 1'b1;
      htrans <= 2'h2;
      haddr <= a;
      hwrite <= wr;
      do begin
         @(posedge hclk);
         k++;
      end while (hreadyout !== 1'b1 && k < 20);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= wd;
      do begin
         @(posedge hclk);
         k++;
      end while (hreadyout !== 1'b1 && k < 40);
      rd = hrdata;
      if (k >= 40) begin
         n_mismatch++;
         conclude;
      end
   endtask
   task wr(input logic [31:0] a, input logic [31:0] d);
      ahb(1'b1, a, d);
   endtask
   task rdc(input logic [31:0] a, input logic [31:0] e);
      ahb(1'b0, a, 32'h0);
      chk(rd, e);
   endtask
   task wo(input int j, input logic [31:0] v);
      wr(32'h18 + 4 * j, v);
      for (int k = 0; k < 4; k++) osel[4 * j + k] = v[8 * k +: 6];
   endtask
   task press(input logic [7:0] m);
      tap <= m;
      tap_go <= 1'b1;
      @(posedge hclk);
      tap_go <= 1'b0;
      repeat (14) @(posedge hclk);
   endtask
   task wait_pin(input int b, input logic v);
      int k;
      for (k = 0; k < 20 && gpio_out[b] !== v; k++) @(posedge hclk);
      chk(gpio_out[b], v);
      if (k == 20) conclude;
   endtask
   task aud(input logic w, input logic [5:0] a);
      aud_wr <= w;
      aud_rd <= !w;
      aud_addr <= a;
      @(posedge hclk);
      aud_wr <= 1'b0;
      aud_rd <= 1'b0;
      repeat (6) @(posedge hclk);
   endtask
   // Model of the function level behind each state and lamp code.
   function automatic logic lvl(input logic [5:0] c);
      case (c)
         6'h23, 6'h24, 6'h25, 6'h26: return lmp[c - 6'h23];
         6'h27, 6'h28, 6'h29: return st[c - 6'h27];
         6'h2A: return st[4];
         6'h2B: return !st[4];
         6'h2C: return st[3];
         6'h2D: return st[5];
         6'h2E: return st[7] & st[3];
         default: return 1'b0;
      endcase
   endfunction
   task cmp_out;
      logic [7:0] e;
      for (int k = 0; k < 8; k++) e[k] = ~lvl(osel[k]);
      chk(gpio_out, e);
   endtask
   initial begin
      repeat (100000) @(posedge hclk);
      n_mismatch++;
      conclude;
   end
   initial begin
      n = $urandom(32'hC9DA);
      repeat (2) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      chk(gpio_out, 8'hFF);
      rdc(32'h00, 32'h0);
      rdc(32'h04, 32'hFA);
      rdc(32'h24, 32'h0);
      wo(1, 32'h2E2D2C2B);
      rdc(32'h1C, 32'h2E2D2C2B);
      wr(32'h10, 32'h1);
      base = cnt;
      press(8'h01);
      chk(cnt[0] - base[0], 0);
      wr(32'h00, 32'h1);
      for (i = 1; i <= 5; i++) begin
         wr(32'h10, i);
         base = cnt;
         press(8'h01);
         chk(cnt[i - 1] - base[i - 1], 1);
      end
      wr(32'h10, 32'h0306);
      level <= 8'h03;
      repeat (8) @(posedge hclk);
      chk({cough_held, ramp_pause}, 2'b11);
      level <= 8'h00;
      repeat (8) @(posedge hclk);
      chk({cough_held, ramp_pause}, 2'b00);
      wr(32'h00, 32'h3);
      wr(32'h08, 32'hA5);
      level <= 8'h81;
      repeat (6) @(posedge hclk);
      rdc(32'h0C, 32'h5A81);
      chk(ramp_pause, 1'b0);
      level <= 8'h00;
      wr(32'h00, 32'h1);
      rdc(32'h08, 32'h0);
      repeat (2) @(posedge hclk);
      cmp_out;
      for (r = 0; r < 2; r++) begin
         for (i = 0; i < 8; i++) sv[8 * i +: 8] = (r * 8 + i > 11) ? 8'h2E : 8'h23 + r * 8 + i;
         wo(0, sv[31:0]);
         wo(1, sv[63:32]);
         repeat (12) begin
            n = $urandom;
            st <= n[7:0];
            lmp <= n[11:8];
            repeat (3) @(posedge hclk);
            cmp_out;
         end
      end
      wr(32'h04, 32'h5);
      rdc(32'h04, 32'h64);
      wr(32'h04, 32'h7FF);
      rdc(32'h04, 32'h3E8);
      wr(32'h04, 32'h64);
      st <= 8'h00;
      // Let pulses started by the random states run out at the old length.
      repeat (2600) @(posedge hclk);
      wo(0, 32'h2221);
      repeat (3) @(posedge hclk);
      st <= 8'h04;
      wait_pin(0, 1'b0);
      for (n = 0; n < 1100 && gpio_out[0] === 1'b0; n++) @(posedge hclk);
      chk(n, 1000);
      repeat (50) @(posedge hclk);
      chk(gpio_out[0], 1'b1);
      st <= 8'h08;
      wait_pin(1, 1'b0);
      wo(0, 32'h04);
      dump_evt <= 1'b1;
      @(posedge hclk);
      dump_evt <= 1'b0;
      wait_pin(0, 1'b0);
      wr(32'h14, 32'h1018);
      wo(1, 32'h1018);
      level <= 8'h10;
      wait_pin(4, 1'b0);
      level <= 8'h20;
      wait_pin(4, 1'b1);
      aud(1'b1, 6'h05);
      level <= 8'h00;
      repeat (6) @(posedge hclk);
      aud(1'b1, 6'h06);
      chk(gpio_out[5], 1'b1);
      aud(1'b0, 6'h05);
      wait_pin(5, 1'b0);
      aud(1'b0, 6'h06);
      wait_pin(5, 1'b1);
      conclude;
   end
endmodule
